// file: src/psdl_pkg.sv
package psdl_pkg;

  // ************************************************
  // Bus geometry
  // ************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************
  // Register offsets (byte addresses)
  // ************************************************
  localparam logic [7:0] OFF_P2_BASIC  = 8'h00;
  localparam logic [7:0] OFF_P2_ADV    = 8'h04;
  localparam logic [7:0] OFF_P2_MODES  = 8'h08;
  localparam logic [7:0] OFF_P2_FC     = 8'h0c;
  localparam logic [7:0] OFF_HOST_FC   = 8'h10;
  localparam logic [7:0] OFF_VPHY_SPEC = 8'h14;
  localparam logic [7:0] OFF_LOAD      = 8'h18;
  localparam logic [7:0] OFF_FC_STAT   = 8'h1c;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int BASIC_SPEED_BIT  = 13;
  localparam int BASIC_AN_BIT     = 12;
  localparam int BASIC_DUPLEX_BIT = 8;
  localparam int ADV_10HD_BIT     = 5;
  localparam int ADV_10FD_BIT     = 6;
  localparam int ADV_PAUSE_BIT    = 10;
  localparam int MODE_LSB         = 0;
  localparam int VPHY_HEARTBEAT_OFF_BIT_BIT  = 0;
  localparam int LOAD_RELOAD_BIT  = 31;
  localparam int LOAD_BUSY_BIT    = 31;
  localparam int STRAP_W          = 10;

  // ************************************************
  // Operating-selection codes
  // ************************************************
  localparam logic [2:0] MODE_10HD  = 3'h0;
  localparam logic [2:0] MODE_10FD  = 3'h1;
  localparam logic [2:0] MODE_100HD = 3'h2;
  localparam logic [2:0] MODE_100FD = 3'h3;
  localparam logic [2:0] MODE_ALL   = 3'h7;

  // ************************************************
  // Carriers
  // ************************************************
  typedef struct packed {
    logic speed100;
    logic duplexFull;
    logic autoneg;
    logic p2Backpress;
    logic p2Pause;
    logic p2Manual;
    logic hostBackpress;
    logic hostPause;
    logic hostManual;
    logic heartbeatOff;
  } psdl_strap_t;

  typedef struct packed {
    logic manual;
    logic backpress;
    logic txPause;
    logic rxPause;
  } psdl_fc_t;

  typedef struct packed {
    logic       speed100;
    logic       duplexFull;
    logic       anEnable;
    logic [2:0] mode;
    logic       adv10Fd;
    logic       adv10Hd;
    logic       advPause;
    logic       heartbeatOff;
  } psdl_phy_cfg_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_APPLY  = 2'b01,
    ST_RUN    = 2'b11
  } psdl_state_t;

  // ************************************************
  // Reset values
  // ************************************************
  localparam psdl_strap_t STRAP_RESET = psdl_strap_t'(10'h3ec);
  localparam psdl_fc_t    FC_RESET    = psdl_fc_t'(4'h0);

  // ************************************************
  // Shared helpers
  // ************************************************
  function automatic psdl_fc_t fcDefault(input logic bp, input logic pause,
                                         input logic man);
    fcDefault = '{manual: man, backpress: bp, txPause: pause, rxPause: pause};
  endfunction

  function automatic logic pauseEffective(input logic man, input logic bit_en,
                                          input logic anRes);
    pauseEffective = man ? bit_en : anRes;
  endfunction

endpackage

// file: src/psdl_strap_capture.sv
`timescale 1ns/1ps
module psdl_strap_capture (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Strap sources
  input  wire psdl_pkg::psdl_strap_t strapPins,
  input  wire logic                  loadReq,
  input  wire psdl_pkg::psdl_strap_t loadStraps,
  // Results
  output logic                       applyPulse,
  output psdl_pkg::psdl_strap_t      straps,
  output logic                       busy
);
  import psdl_pkg::*;

  psdl_state_t state_reg;
  psdl_state_t state_next;
  psdl_strap_t straps_next;
  logic        apply_next;
  logic        busy_next;

  // ************************************************
  // Sequencer
  // ************************************************
  always_comb begin
    state_next  = state_reg;
    straps_next = straps;
    apply_next  = 1'b0;
    busy_next   = 1'b1;
    case (state_reg)
      ST_SAMPLE: begin
        // Pins caught after release, never under reset
        straps_next = strapPins;
        state_next  = ST_APPLY;
      end
      ST_APPLY: begin
        apply_next = 1'b1;
        busy_next  = 1'b0;
        state_next = ST_RUN;
      end
      default: begin
        busy_next = 1'b0;
        if (loadReq) begin
          // Loaded values replace pin values
          straps_next = loadStraps;
          busy_next   = 1'b1;
          state_next  = ST_APPLY;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_SAMPLE;
      straps     <= STRAP_RESET;
      applyPulse <= 1'b0;
      busy       <= 1'b1;
    end else begin
      state_reg  <= state_next;
      straps     <= straps_next;
      applyPulse <= apply_next;
      busy       <= busy_next;
    end
  end

endmodule // psdl_strap_capture

// file: src/psdl_pause_resolve.sv
`timescale 1ns/1ps
module psdl_pause_resolve (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Settings and negotiated result
  input  wire psdl_pkg::psdl_fc_t fc,
  input  wire logic               anTxPause,
  input  wire logic               anRxPause,
  // Effective enables
  output logic                    txPauseEn,
  output logic                    rxPauseEn,
  output logic                    backpressEn
);
  import psdl_pkg::*;

  logic txNext;
  logic rxNext;
  logic bpNext;

  always_comb begin
    // Pause enable bits only count under manual select; backpress always counts
    txNext = pauseEffective(fc.manual, fc.txPause, anTxPause);
    rxNext = pauseEffective(fc.manual, fc.rxPause, anRxPause);
    bpNext = fc.backpress;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txPauseEn   <= 1'b0;
      rxPauseEn   <= 1'b0;
      backpressEn <= 1'b0;
    end else begin
      txPauseEn   <= txNext;
      rxPauseEn   <= rxNext;
      backpressEn <= bpNext;
    end
  end

endmodule // psdl_pause_resolve

// file: src/psdl_top.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module psdl_top (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Strap sources
  input  wire psdl_pkg::psdl_strap_t   strapPins,
  input  wire logic                    eeLoadValid,
  input  wire psdl_pkg::psdl_strap_t   eeLoadStraps,
  // Negotiated pause results
  input  wire logic                    p2AnTxPause,
  input  wire logic                    p2AnRxPause,
  input  wire logic                    hostAnTxPause,
  input  wire logic                    hostAnRxPause,
  // Configuration out
  output psdl_pkg::psdl_phy_cfg_t      phyCfg,
  output psdl_pkg::psdl_fc_t           p2FcCfg,
  output psdl_pkg::psdl_fc_t           hostFcCfg,
  output logic                         strapBusy,
  // Effective flow control
  output logic                         p2TxPauseEn,
  output logic                         p2RxPauseEn,
  output logic                         p2BackpressEn,
  output logic                         hostTxPauseEn,
  output logic                         hostRxPauseEn,
  output logic                         hostBackpressEn
);
  import psdl_pkg::*;

  // ************************************************
  // Declarations
  // ************************************************
  psdl_strap_t   straps;
  logic          applyPulse;
  logic          loadReq;
  psdl_strap_t   loadStraps;
  psdl_phy_cfg_t phyCfg_next;
  psdl_fc_t      p2Fc_next;
  psdl_fc_t      hostFc_next;
  psdl_strap_t   swStraps_reg;
  psdl_strap_t   swStraps_next;
  logic          swLoad_reg;
  logic          swLoad_next;
  logic [31:0]   prdata_next;
  logic          pready_next;
  logic          pslverr_next;
  logic          setupPhase;
  logic          wrAccess;
  logic          hitBasic;
  logic          hitAdv;
  logic          hitModes;
  logic          hitP2Fc;
  logic          hitHostFc;
  logic          hitVphy;
  logic          hitLoad;
  logic          hitStat;
  logic          mapped;

  // ************************************************
  // Default derivation
  // ************************************************
  function automatic psdl_phy_cfg_t cfgDefault(input psdl_strap_t s);
    psdl_phy_cfg_t c;
    c              = '0;
    c.speed100     = s.speed100;
    c.duplexFull   = s.duplexFull;
    c.anEnable     = s.autoneg;
    // Forced 10BASE-T advertises 10HD, plus 10FD at full duplex; forced 100 advertises neither
    c.adv10Hd      = s.autoneg | ~s.speed100;
    c.adv10Fd      = s.autoneg | (~s.speed100 & s.duplexFull);
    if (s.autoneg) begin
      c.mode = MODE_ALL;
    end else if (s.speed100) begin
      c.mode = s.duplexFull ? MODE_100FD : MODE_100HD;
    end else begin
      c.mode = s.duplexFull ? MODE_10FD : MODE_10HD;
    end
    // Host manual strap has no advertisement effect
    c.advPause     = ~s.p2Manual;
    c.heartbeatOff = s.heartbeatOff;
    cfgDefault     = c;
  endfunction

  // ************************************************
  // Strap capture and loader
  // ************************************************
  // External loader wins over a software load in the same cycle
  always_comb begin
    loadReq    = eeLoadValid | swLoad_reg;
    loadStraps = eeLoadValid ? eeLoadStraps : swStraps_reg;
  end

  // Loader requests during a capture are dropped, not queued
  psdl_strap_capture u_capture (
    .clk        (clk),
    .reset_n    (reset_n),
    .strapPins  (strapPins),
    .loadReq    (loadReq),
    .loadStraps (loadStraps),
    .applyPulse (applyPulse),
    .straps     (straps),
    .busy       (strapBusy)
  );

  // ************************************************
  // Address decode
  // ************************************************
  always_comb begin
    hitBasic  = 1'b0;
    hitAdv    = 1'b0;
    hitModes  = 1'b0;
    hitP2Fc   = 1'b0;
    hitHostFc = 1'b0;
    hitVphy   = 1'b0;
    hitLoad   = 1'b0;
    hitStat   = 1'b0;
    if (paddr == OFF_P2_BASIC) begin
      hitBasic = 1'b1;
    end else if (paddr == OFF_P2_ADV) begin
      hitAdv = 1'b1;
    end else if (paddr == OFF_P2_MODES) begin
      hitModes = 1'b1;
    end else if (paddr == OFF_P2_FC) begin
      hitP2Fc = 1'b1;
    end else if (paddr == OFF_HOST_FC) begin
      hitHostFc = 1'b1;
    end else if (paddr == OFF_VPHY_SPEC) begin
      hitVphy = 1'b1;
    end else if (paddr == OFF_LOAD) begin
      hitLoad = 1'b1;
    end else if (paddr == OFF_FC_STAT) begin
      hitStat = 1'b1;
    end
    // Unmapped offsets answer with an error and read zero
    mapped = hitBasic | hitAdv | hitModes | hitP2Fc | hitHostFc
           | hitVphy | hitLoad | hitStat;
  end

  // ************************************************
  // APB answer
  // ************************************************
  // Answer prepared in setup so every access ends in one cycle
  // Reads show the configuration as it stood in the setup cycle
  always_comb begin
    setupPhase   = psel & ~penable;
    // Write data taken only at the edge that ends the access
    wrAccess     = psel & penable & pready & pwrite & ~pslverr;
    pready_next  = setupPhase;
    pslverr_next = setupPhase & ~mapped;
    prdata_next  = '0;
    if (setupPhase & ~pwrite) begin
      if (hitBasic) begin
        prdata_next[BASIC_SPEED_BIT]  = phyCfg.speed100;
        prdata_next[BASIC_AN_BIT]     = phyCfg.anEnable;
        prdata_next[BASIC_DUPLEX_BIT] = phyCfg.duplexFull;
      end else if (hitAdv) begin
        prdata_next[ADV_10HD_BIT]  = phyCfg.adv10Hd;
        prdata_next[ADV_10FD_BIT]  = phyCfg.adv10Fd;
        prdata_next[ADV_PAUSE_BIT] = phyCfg.advPause;
      end else if (hitModes) begin
        prdata_next[MODE_LSB +: 3] = phyCfg.mode;
      end else if (hitP2Fc) begin
        prdata_next[3:0] = p2FcCfg;
      end else if (hitHostFc) begin
        prdata_next[3:0] = hostFcCfg;
      end else if (hitVphy) begin
        prdata_next[VPHY_HEARTBEAT_OFF_BIT_BIT] = phyCfg.heartbeatOff;
      end else if (hitLoad) begin
        prdata_next[STRAP_W-1:0]   = straps;
        prdata_next[LOAD_BUSY_BIT] = strapBusy;
      end else if (hitStat) begin
        prdata_next[5:0] = {hostBackpressEn, hostTxPauseEn, hostRxPauseEn,
                            p2BackpressEn, p2TxPauseEn, p2RxPauseEn};
      end
    end
  end

  // ************************************************
  // APB answer registers
  // ************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_next;
      pready  <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ************************************************
  // Configuration registers
  // ************************************************
  // A default apply in the same cycle as a write wins: it is a reload
  always_comb begin
    phyCfg_next   = phyCfg;
    p2Fc_next     = p2FcCfg;
    hostFc_next   = hostFcCfg;
    swStraps_next = swStraps_reg;
    swLoad_next   = 1'b0;
    if (applyPulse) begin
      phyCfg_next = cfgDefault(straps);
      p2Fc_next   = fcDefault(straps.p2Backpress, straps.p2Pause,
                              straps.p2Manual);
      hostFc_next = fcDefault(straps.hostBackpress, straps.hostPause,
                              straps.hostManual);
    end else if (wrAccess) begin
      // Software writes after reset override the defaults
      // Status word is read-only, so writes there change nothing
      if (hitBasic) begin
        phyCfg_next.speed100   = pwdata[BASIC_SPEED_BIT];
        phyCfg_next.anEnable   = pwdata[BASIC_AN_BIT];
        phyCfg_next.duplexFull = pwdata[BASIC_DUPLEX_BIT];
      end else if (hitAdv) begin
        phyCfg_next.adv10Hd  = pwdata[ADV_10HD_BIT];
        phyCfg_next.adv10Fd  = pwdata[ADV_10FD_BIT];
        phyCfg_next.advPause = pwdata[ADV_PAUSE_BIT];
      end else if (hitModes) begin
        phyCfg_next.mode = pwdata[MODE_LSB +: 3];
      end else if (hitP2Fc) begin
        p2Fc_next = psdl_fc_t'(pwdata[3:0]);
      end else if (hitHostFc) begin
        hostFc_next = psdl_fc_t'(pwdata[3:0]);
      end else if (hitVphy) begin
        phyCfg_next.heartbeatOff = pwdata[VPHY_HEARTBEAT_OFF_BIT_BIT];
      end
    end
    if (wrAccess & hitLoad) begin
      swStraps_next = psdl_strap_t'(pwdata[STRAP_W-1:0]);
      swLoad_next   = pwdata[LOAD_RELOAD_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phyCfg       <= '0;
      p2FcCfg      <= FC_RESET;
      hostFcCfg    <= FC_RESET;
      swStraps_reg <= STRAP_RESET;
      swLoad_reg   <= 1'b0;
    end else begin
      phyCfg       <= phyCfg_next;
      p2FcCfg      <= p2Fc_next;
      hostFcCfg    <= hostFc_next;
      swStraps_reg <= swStraps_next;
      swLoad_reg   <= swLoad_next;
    end
  end

  // ************************************************
  // Flow control resolution
  // ************************************************
  // Effective enables trail the configuration by one clock
  psdl_pause_resolve u_p2_resolve (
    .clk         (clk),
    .reset_n     (reset_n),
    .fc          (p2FcCfg),
    .anTxPause   (p2AnTxPause),
    .anRxPause   (p2AnRxPause),
    .txPauseEn   (p2TxPauseEn),
    .rxPauseEn   (p2RxPauseEn),
    .backpressEn (p2BackpressEn)
  );

  psdl_pause_resolve u_host_resolve (
    .clk         (clk),
    .reset_n     (reset_n),
    .fc          (hostFcCfg),
    .anTxPause   (hostAnTxPause),
    .anRxPause   (hostAnRxPause),
    .txPauseEn   (hostTxPauseEn),
    .rxPauseEn   (hostRxPauseEn),
    .backpressEn (hostBackpressEn)
  );

endmodule // psdl_top

// file: test/psdl_monitor.sv
`timescale 1ns/1ps
module psdl_monitor (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    reset_n,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  // Straps and configuration
  input wire psdl_pkg::psdl_strap_t   strapPins,
  input wire logic                    eeLoadValid,
  input wire logic                    p2AnTxPause,
  input wire logic                    hostAnRxPause,
  input wire psdl_pkg::psdl_phy_cfg_t phyCfg,
  input wire psdl_pkg::psdl_fc_t      p2FcCfg,
  input wire psdl_pkg::psdl_fc_t      hostFcCfg,
  input wire logic                    strapBusy,
  input wire logic                    p2TxPauseEn,
  input wire logic                    hostRxPauseEn
);
  import psdl_pkg::*;
  // ********
  // Helpers
  // ********
  psdl_strap_t pinsOld;
  logic        fcWrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Straps as seen three edges back, when the capture took them
  always_ff @(posedge clk) pinsOld <= $past(strapPins, 2);
  assign fcWrite = psel && penable && pready && pwrite && (paddr == OFF_P2_FC);
  // ********
  // Properties
  // ********
  property p_pready;
    psel && !penable |=> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready missing");
  property p_busy;
    $rose(reset_n) |-> strapBusy ##[1:3] !strapBusy;
  endproperty
  a_busy: assert property (p_busy) else $error("strap busy stuck");
  property p_speed;
    $rose(reset_n) |-> ##3 phyCfg.speed100 == pinsOld.speed100;
  endproperty
  a_speed: assert property (p_speed) else $error("speed default wrong");
  property p_duplex;
    $rose(reset_n) |-> ##3 phyCfg.duplexFull == pinsOld.duplexFull;
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex default wrong");
  property p_pause_adv;
    $rose(reset_n) |-> ##3 phyCfg.advPause != pinsOld.p2Manual;
  endproperty
  a_pause_adv: assert property (p_pause_adv) else $error("pause advert wrong");
  property p_heartbeat;
    $rose(reset_n) |-> ##3 phyCfg.heartbeatOff == pinsOld.heartbeatOff;
  endproperty
  a_heartbeat: assert property (p_heartbeat) else $error("heartbeat wrong");
  property p_p2_fc;
    $rose(reset_n) |-> ##3
      p2FcCfg == {pinsOld.p2Manual, pinsOld.p2Backpress, {2{pinsOld.p2Pause}}};
  endproperty
  a_p2_fc: assert property (p_p2_fc) else $error("port fc default wrong");
  property p_host_fc;
    $rose(reset_n) |-> ##3
      hostFcCfg == {pinsOld.hostManual, pinsOld.hostBackpress, {2{pinsOld.hostPause}}};
  endproperty
  a_host_fc: assert property (p_host_fc) else $error("host fc default wrong");
  property p_p2_tx;
    $past(reset_n) |->
      p2TxPauseEn == ($past(p2FcCfg.manual) ? $past(p2FcCfg.txPause)
                                            : $past(p2AnTxPause));
  endproperty
  a_p2_tx: assert property (p_p2_tx) else $error("port tx pause wrong");
  property p_host_rx;
    $past(reset_n) |->
      hostRxPauseEn == ($past(hostFcCfg.manual) ? $past(hostFcCfg.rxPause)
                                                : $past(hostAnRxPause));
  endproperty
  a_host_rx: assert property (p_host_rx) else $error("host rx pause wrong");
  property p_fc_write;
    fcWrite && !strapBusy && !$past(strapBusy) |=> p2FcCfg == $past(pwdata[3:0]);
  endproperty
  a_fc_write: assert property (p_fc_write) else $error("fc write lost");
  property p_load_busy;
    eeLoadValid && !strapBusy && !$past(strapBusy) |-> ##[1:2] strapBusy;
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("load ignored");
  c_reload: cover property (eeLoadValid && !strapBusy);
  c_manual: cover property (p2FcCfg.manual && p2TxPauseEn);
  c_write: cover property (fcWrite);
endmodule  // psdl_monitor

bind psdl_top psdl_monitor u_monitor (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .strapPins, .eeLoadValid, .p2AnTxPause, .hostAnRxPause, .phyCfg,
  .p2FcCfg, .hostFcCfg, .strapBusy, .p2TxPauseEn, .hostRxPauseEn);

// file: test/test_psdl_top.sv
`timescale 1ns/1ps
module test_psdl_top;
  import psdl_pkg::*;
  // ********
  // Signals
  // ********
  logic        clk, reset_n, psel, penable, pwrite, eeLoadValid;
  logic        pready, pslverr, strapBusy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  anIn;
  logic [32:0] notes[$];
  psdl_strap_t strapPins, eeLoadStraps, s, t;
  int          fails, compares;

  psdl_top DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .strapPins, .eeLoadValid, .eeLoadStraps,
    .p2AnTxPause(anIn[3]), .p2AnRxPause(anIn[2]), .hostAnTxPause(anIn[1]),
    .hostAnRxPause(anIn[0]), .phyCfg(), .p2FcCfg(), .hostFcCfg(), .strapBusy,
    .p2TxPauseEn(), .p2RxPauseEn(), .p2BackpressEn(), .hostTxPauseEn(),
    .hostRxPauseEn(), .hostBackpressEn());

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ********
  // Expected register contents
  // ********
  function automatic logic [31:0] expReg(input logic [7:0] a, input psdl_strap_t x);
    logic hd;
    hd = x.autoneg | ~x.speed100;
    case (a)
      OFF_P2_BASIC: expReg = 32'({x.speed100, x.autoneg, 3'h0, x.duplexFull, 8'h00});
      OFF_P2_ADV: expReg = 32'({~x.p2Manual, 3'h0, hd & (x.autoneg | x.duplexFull), hd,
                               5'h00});
      OFF_P2_MODES: expReg = x.autoneg ? 32'h0000_0007 : 32'({x.speed100, x.duplexFull});
      OFF_P2_FC: expReg = 32'({x.p2Manual, x.p2Backpress, x.p2Pause, x.p2Pause});
      OFF_HOST_FC: expReg = 32'({x.hostManual, x.hostBackpress, x.hostPause, x.hostPause});
      OFF_VPHY_SPEC: expReg = 32'(x.heartbeatOff);
      OFF_LOAD: expReg = 32'(x);
      OFF_FC_STAT: expReg = 32'({x.hostBackpress, x.hostManual ? x.hostPause : anIn[1],
        x.hostManual ? x.hostPause : anIn[0], x.p2Backpress,
        x.p2Manual ? x.p2Pause : anIn[3], x.p2Manual ? x.p2Pause : anIn[2]});
      default: expReg = 32'h0000_0000;
    endcase
  endfunction

  // ********
  // Checking and closing
  // ********
  task automatic cmp_rsp(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Oldest note pairs with each completed transfer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      cmp_rsp({pslverr, prdata}, notes.pop_front());
    end
  end

  // ********
  // Bus and load tasks
  // ********
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    notes.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input psdl_strap_t x);
    apb(1'b0, a, 32'h0000_0000, {1'b0, expReg(a, x)});
  endtask

  task automatic checkAll(input psdl_strap_t x);
    rd(OFF_P2_BASIC, x);
    rd(OFF_P2_ADV, x);
    rd(OFF_P2_MODES, x);
    rd(OFF_P2_FC, x);
    rd(OFF_HOST_FC, x);
    rd(OFF_VPHY_SPEC, x);
    rd(OFF_LOAD, x);
    rd(OFF_FC_STAT, x);
  endtask

  // Loader timing is fixed, but busy is still polled under a bound
  task automatic load(input psdl_strap_t x, input int how);
    int n;
    case (how)
      0: begin
        strapPins <= x;
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
      end
      1: begin
        eeLoadStraps <= x;
        eeLoadValid <= 1'b1;
        @(posedge clk);
        eeLoadValid <= 1'b0;
        eeLoadStraps <= ~x;
      end
      default: apb(1'b1, OFF_LOAD, {1'b1, 21'h0, x}, 33'h0);
    endcase
    repeat (2) @(posedge clk);
    for (n = 0; strapBusy !== 1'b0 && n < 20; n++) @(posedge clk);
    if (n == 20) begin
      fails++;
      wrap_up();
    end
    repeat (6) @(posedge clk);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    eeLoadValid = 1'b0;
    eeLoadStraps = '0;
    strapPins = STRAP_RESET;
    anIn = 4'h0;
    void'($urandom(92563));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    checkAll(STRAP_RESET);
    for (int i = 0; i < 12; i++) begin
      s = psdl_strap_t'(10'($urandom));
      if (i < 8) begin
        s.autoneg = 1'b0;
        s.speed100 = i[0];
        s.duplexFull = i[1];
        s.p2Manual = i[2];
        s.hostManual = ~i[2];
        s.heartbeatOff = i[0] ^ i[2];
      end
      anIn <= 4'($urandom);
      load(s, i % 3);
      checkAll(s);
    end
    // Software overrides, then a reload restores the defaults
    for (int k = 0; k < 2; k++) begin
      t = s;
      t.speed100 = ~s.speed100;
      t.duplexFull = k[0];
      t.autoneg = ~k[0];
      t.heartbeatOff = ~s.heartbeatOff;
      t.p2Manual = k[0];
      t.p2Backpress = ~k[0];
      t.p2Pause = k[0];
      t.hostManual = ~k[0];
      t.hostBackpress = k[0];
      t.hostPause = ~k[0];
      anIn <= ~anIn;
      apb(1'b1, OFF_P2_BASIC, expReg(OFF_P2_BASIC, t), 33'h0);
      apb(1'b1, OFF_P2_ADV, expReg(OFF_P2_ADV, t), 33'h0);
      apb(1'b1, OFF_P2_MODES, expReg(OFF_P2_MODES, t), 33'h0);
      apb(1'b1, OFF_VPHY_SPEC, expReg(OFF_VPHY_SPEC, t), 33'h0);
      apb(1'b1, OFF_P2_FC, expReg(OFF_P2_FC, t), 33'h0);
      apb(1'b1, OFF_HOST_FC, expReg(OFF_HOST_FC, t), 33'h0);
      apb(1'b1, OFF_FC_STAT, 32'hffff_ffff, 33'h0);
      rd(OFF_P2_BASIC, t);
      rd(OFF_P2_ADV, t);
      rd(OFF_P2_MODES, t);
      rd(OFF_VPHY_SPEC, t);
      rd(OFF_HOST_FC, t);
      rd(OFF_P2_FC, t);
      rd(OFF_FC_STAT, t);
    end
    apb(1'b0, 8'h20, 32'h0000_0000, {1'b1, 32'h0000_0000});
    load(s, 1);
    checkAll(s);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule  // test_psdl_top
